// [swc_far_side.sv]
`timescale 1ns/10ps
module swc_far_side (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// commands from the bench
	input  wire logic       bus_want,
	input  wire logic [7:0] hold,
	input  wire logic       nmi_fire,
	input  wire logic [2:0] irq_lvl,
	// answer from the device
	input  wire logic       bus_hold_grant_n,
	// pins, pulled high when idle
	output logic            bus_hold_request_n,
	output logic            nmi_n,
	output logic      [2:0] irq_n
);
	logic [7:0] held_r;
	logic [1:0] nmi_r;

	// the master keeps the bus for hold cycles after grant, then lets go
	always_ff @(posedge clk) begin
		if (sys_rst || !bus_want)
			held_r <= 8'h00;
		else if (!bus_hold_grant_n && held_r != hold)
			held_r <= held_r + 8'h01;
	end
	assign bus_hold_request_n = ~(bus_want && held_r != hold);

	// short low pulse, gone long before the counter expires
	always_ff @(posedge clk) begin
		// without a reset the pin would float unknown until the first pulse
		if (sys_rst)
			nmi_r <= 2'h0;
		else if (nmi_fire)
			nmi_r <= 2'h3;
		else if (nmi_r != 2'h0)
			nmi_r <= nmi_r - 2'h1;
	end
	assign nmi_n = (nmi_r == 2'h0);
	assign irq_n = ~irq_lvl;
endmodule : swc_far_side

// [swc_pkg.sv]
package swc_pkg;
	// register offsets on the internal i/o port
	localparam logic [7:0] SWC_IRQCTL_OFF = 8'h34;
	localparam logic [7:0] SWC_IOC_OFF    = 8'h3f;
	localparam logic [7:0] SWC_CPUCTL_OFF = 8'h1f;
	// interrupt_trap_control fields
	localparam int SWC_IRQCTL_EN_LSB    = 0;
	localparam int SWC_IRQCTL_CAUSE_LSB = 3;
	// cpu_control_reg fields
	localparam int SWC_CPUCTL_BRWE_BIT  = 5;
	localparam int SWC_CPUCTL_D6_BIT    = 6;
	localparam int SWC_CPUCTL_D3_BIT    = 3;
	// io_control fields
	localparam int SWC_IOC_STOP_BIT     = 5;
	// values after reset
	localparam logic [7:0] SWC_IRQCTL_RST = 8'h01;
	localparam logic [7:0] SWC_IOC_RST    = 8'h00;
	localparam logic [7:0] SWC_CPUCTL_RST = 8'h00;
	// oscillator stabilization interval in clocks
	localparam int SWC_STAB_CLOCKS = 2 ** 17;
	localparam int SWC_NUM_IRQ     = 3;

	typedef enum logic [2:0] {
		SWC_RUN,
		SWC_STANDBY,
		SWC_STAB,
		SWC_HELD,
		SWC_RECLAIM
	} swc_state_t;
endpackage : swc_pkg

// [swc_stab_counter.sv]
`timescale 1ns/10ps
module swc_stab_counter
	import swc_pkg::*;
#(
	parameter int CYCLES = SWC_STAB_CLOCKS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// control
	swc_stab_if.cnt   stab
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD_VAL = W'(CYCLES - 1);

	logic [W-1:0] cnt_r;
	logic         run_r;
	wire          at_zero = (cnt_r == '0);

	// a load while running restarts the interval from the top
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (stab.load) begin
			cnt_r <= LOAD_VAL;
			run_r <= 1'b1;
		end else if (run_r) begin
			cnt_r <= at_zero ? cnt_r : cnt_r - W'(1);
			run_r <= !at_zero;
		end
	end

	assign stab.done = run_r && at_zero;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_load_no_done: assert property (stab.load |=> !stab.done)
		else $error("stabilization done right after load");
	a_done_single: assert property (stab.done |=> !stab.done)
		else $error("done lasted more than one cycle");
endmodule : swc_stab_counter

// [swc_stab_if.sv]
`timescale 1ns/10ps
interface swc_stab_if;
	logic load;
	logic done;
	modport ctl (output load, input done);
	modport cnt (input load, output done);
endinterface : swc_stab_if

// [swc_standby_wake.sv]
`timescale 1ns/10ps
module swc_standby_wake
	import swc_pkg::*;
#(
	parameter int STAB_CYCLES = SWC_STAB_CLOCKS
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// internal i/o register port
	input  wire logic [7:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	// cpu core
	input  wire logic       sleep_exec,
	input  wire logic       global_irq_enable_flag,
	output logic            nmi_ack_start,
	output logic            irq_ack_start,
	output logic      [1:0] irq_ack_id,
	output logic            sleep_resume,
	output logic            idle_select,
	// clocking
	output logic            osc_enable,
	output logic            clk_run,
	// pins
	input  wire logic       bus_hold_request_n,
	input  wire logic       nmi_n,
	input  wire logic       maskable_irq0_in_n,
	input  wire logic       maskable_irq1_in_n,
	input  wire logic       maskable_irq2_in_n,
	output logic            bus_hold_grant_n,
	output logic            bus_oe,
	output logic            bus_park_high
);
	localparam int N = SWC_NUM_IRQ;

	swc_state_t state_r, state_nxt;
	logic [7:0] irqctl_r, ioc_r, cpuctl_r, rdata_r;
	logic [N+1:0] s1_r, s2_r;
	logic nmi_d_r, nmi_lat_r, grant_n_r;
	logic cause_bus_r, cause_irq_r;
	logic nmi_ack_r, irq_ack_r, resume_r;
	logic [1:0] ack_id_r;

	swc_stab_if stab ();
	swc_stab_counter #(.CYCLES(STAB_CYCLES)) u_cnt (
		.clk     (clk),
		.sys_rst (sys_rst),
		.stab    (stab)
	);

	// pin inputs pass two flops; only the second stage is used
	wire [N+1:0] pins_in = {~nmi_n, ~bus_hold_request_n, ~maskable_irq2_in_n,
		~maskable_irq1_in_n, ~maskable_irq0_in_n};
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= pins_in;
			s2_r <= s1_r;
		end
	end

	wire [N-1:0] irq_lvl  = s2_r[N-1:0];
	wire         breq     = s2_r[N];
	wire         nmi_lvl  = s2_r[N+1];
	wire         nmi_fall = nmi_lvl && !nmi_d_r;
	wire [N-1:0] irq_en   = irqctl_r[SWC_IRQCTL_EN_LSB +: N];
	wire         brwe     = cpuctl_r[SWC_CPUCTL_BRWE_BIT];

	// register decode
	wire sel_irqctl = (io_addr == SWC_IRQCTL_OFF);
	wire sel_ioc    = (io_addr == SWC_IOC_OFF);
	wire sel_cpuctl = (io_addr == SWC_CPUCTL_OFF);
	wire [7:0] irqctl_view = {2'b00, cause_irq_r, cause_bus_r, nmi_lat_r, irqctl_r[N-1:0]};
	wire [7:0] rd_mux = sel_irqctl ? irqctl_view : sel_ioc ? ioc_r
		: sel_cpuctl ? cpuctl_r : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqctl_r <= SWC_IRQCTL_RST;
			ioc_r    <= SWC_IOC_RST;
			cpuctl_r <= SWC_CPUCTL_RST;
			rdata_r  <= 8'h00;
		end else begin
			if (io_wr && sel_irqctl)
				irqctl_r <= {5'h00, io_wdata[N-1:0]};
			if (io_wr && sel_ioc)
				ioc_r <= io_wdata;
			if (io_wr && sel_cpuctl)
				cpuctl_r <= io_wdata;
			if (io_rd)
				rdata_r <= rd_mux;
		end
	end

	// wake qualification; masked inputs are ignored regardless of the global flag
	wire wake_bus  = brwe && breq;
	wire [N-1:0] irq_live_v = irq_en & irq_lvl;
	wire irq_live  = |irq_live_v;
	wire wake_any  = wake_bus || nmi_fall || nmi_lat_r || irq_live;
	wire standby_cfg = cpuctl_r[SWC_CPUCTL_D6_BIT] && cpuctl_r[SWC_CPUCTL_D3_BIT];
	wire done      = stab.done;
	wire [1:0] live_id = irq_live_v[0] ? 2'd0 : irq_live_v[1] ? 2'd1 : 2'd2;

	// decision when the counter expires, nmi first
	wire go_nmi    = done && nmi_lat_r;
	wire go_irq    = done && !nmi_lat_r && cause_irq_r && irq_live;
	wire go_bus    = done && !nmi_lat_r && !go_irq && cause_bus_r;
	wire abandon   = done && !nmi_lat_r && !go_irq && !cause_bus_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SWC_RUN:
				if (breq)
					state_nxt = SWC_HELD;
				else if (sleep_exec && standby_cfg)
					state_nxt = SWC_STANDBY;
			SWC_STANDBY:
				if (wake_any)
					state_nxt = SWC_STAB;
			SWC_STAB:
				if (go_bus)
					state_nxt = SWC_HELD;
				else if (abandon)
					state_nxt = SWC_STANDBY;
				else if (done)
					state_nxt = SWC_RUN;
			SWC_HELD:
				if (!breq)
					state_nxt = SWC_RECLAIM;
			SWC_RECLAIM:
				state_nxt = SWC_RUN;
		endcase
	end

	assign stab.load = (state_r == SWC_STANDBY) && wake_any;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r   <= SWC_RUN;
			nmi_d_r   <= 1'b0;
			nmi_lat_r <= 1'b0;
			grant_n_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			nmi_d_r   <= nmi_lvl;
			// a new edge in the consuming cycle keeps the latch set
			if (nmi_fall && state_r != SWC_RUN)
				nmi_lat_r <= 1'b1;
			else if (go_nmi)
				nmi_lat_r <= 1'b0;
			// grant one cycle after the bus floats, dropped as it is reclaimed
			grant_n_r <= !(state_r == SWC_HELD && state_nxt == SWC_HELD);
		end
	end

	// wake cause captured at exit, held for software to read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cause_bus_r <= 1'b0;
			cause_irq_r <= 1'b0;
		end else if (stab.load) begin
			cause_bus_r <= wake_bus;
			cause_irq_r <= irq_live;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nmi_ack_r <= 1'b0;
			irq_ack_r <= 1'b0;
			resume_r  <= 1'b0;
			ack_id_r  <= 2'd0;
		end else begin
			nmi_ack_r <= go_nmi;
			irq_ack_r <= go_irq && global_irq_enable_flag;
			resume_r  <= (go_irq && !global_irq_enable_flag) || (state_r == SWC_RECLAIM);
			ack_id_r  <= go_irq ? live_id : ack_id_r;
		end
	end

	assign io_rdata         = rdata_r;
	assign nmi_ack_start    = nmi_ack_r;
	assign irq_ack_start    = irq_ack_r;
	assign irq_ack_id       = ack_id_r;
	assign sleep_resume     = resume_r;
	// software alone chooses idle; this only reports the selection
	assign idle_select      = !cpuctl_r[SWC_CPUCTL_D6_BIT] && cpuctl_r[SWC_CPUCTL_D3_BIT]
		&& ioc_r[SWC_IOC_STOP_BIT];
	assign osc_enable       = (state_r != SWC_STANDBY);
	assign clk_run          = (state_r != SWC_STANDBY) && (state_r != SWC_STAB);
	assign bus_hold_grant_n = grant_n_r;
	assign bus_oe           = (state_r != SWC_HELD);
	assign bus_park_high    = (state_r == SWC_RECLAIM);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_bus_wake_gate: assert property ((state_r == SWC_STANDBY) && breq && !brwe && !nmi_fall
		&& !nmi_lat_r && !irq_live |=> state_r == SWC_STANDBY)
		else $error("standby left on disabled bus request");
	a_bus_wake_go: assert property ((state_r == SWC_STANDBY) && wake_bus
		|=> state_r == SWC_STAB && osc_enable && !clk_run)
		else $error("bus request did not start wake");
	a_clock_held: assert property ((state_r == SWC_STAB) |-> !clk_run)
		else $error("clocking resumed before stabilization");
	a_float_grant: assert property ($rose(state_r == SWC_HELD) |-> !bus_oe && bus_hold_grant_n
		##1 !bus_hold_grant_n)
		else $error("grant not after bus float");
	a_reclaim_high: assert property ((state_r == SWC_HELD) && !breq
		|=> bus_park_high && bus_oe && bus_hold_grant_n ##1 sleep_resume)
		else $error("bus not reclaimed high");
	a_stay_released: assert property ((state_r == SWC_RUN) && breq
		|=> !bus_oe ##1 !bus_hold_grant_n)
		else $error("bus not released after exit");
	a_nmi_ack: assert property (done && nmi_lat_r |=> nmi_ack_start && !irq_ack_start)
		else $error("nmi acknowledge missing");
	a_nmi_latch: assert property (nmi_fall && (state_r == SWC_STAB) && !done
		|=> nmi_lat_r)
		else $error("nmi edge not latched");
	a_mask_block: assert property ((state_r == SWC_STANDBY) && !wake_bus && !nmi_fall
		&& !nmi_lat_r && ((irq_lvl & ~irq_en) != '0) && !irq_live
		|=> state_r == SWC_STANDBY)
		else $error("masked input ended standby");
	a_irq_ack: assert property (go_irq && global_irq_enable_flag
		|=> irq_ack_start && !sleep_resume)
		else $error("maskable acknowledge missing");
	a_irq_noack: assert property (go_irq && !global_irq_enable_flag
		|=> sleep_resume && !irq_ack_start)
		else $error("resume without acknowledge missing");
	a_exit_abandon: assert property (abandon |=> state_r == SWC_STANDBY && !osc_enable)
		else $error("exit completed without live input");

	c_bus_wake: cover property ((state_r == SWC_STANDBY) && wake_bus ##[1:300] go_bus);
	c_nmi_wake: cover property (go_nmi);
	c_irq_ack: cover property (go_irq && global_irq_enable_flag);
	c_abandon: cover property (abandon);
endmodule : swc_standby_wake

// [swc_standby_wake_tb_top.sv]
`timescale 1ns/10ps
module swc_standby_wake_tb_top
	import swc_pkg::*;
;
	localparam int STAB = 16;
	logic        clk, sys_rst, io_wr, io_rd, sleep_exec, bus_want, nmi_fire;
	logic        global_irq_enable_flag, nmi_ack_start, irq_ack_start, sleep_resume;
	logic        idle_select, osc_enable, clk_run, bus_hold_request_n, nmi_n;
	logic        bus_hold_grant_n, bus_oe, bus_park_high;
	logic [7:0]  io_addr, io_wdata, io_rdata, rv, hold;
	logic [2:0]  irq_lvl, irq_n;
	logic [1:0]  irq_ack_id;
	logic [3:0]  ev;
	logic [31:0] seed;
	int          fails, compares, parks, n;

	swc_standby_wake #(.STAB_CYCLES(STAB)) swc_standby_wake_inst (.clk, .sys_rst, .io_addr,
		.io_wr, .io_rd, .io_wdata, .io_rdata, .sleep_exec, .global_irq_enable_flag,
		.nmi_ack_start, .irq_ack_start, .irq_ack_id, .sleep_resume, .idle_select,
		.osc_enable, .clk_run, .bus_hold_request_n, .nmi_n,
		.maskable_irq0_in_n(irq_n[0]), .maskable_irq1_in_n(irq_n[1]),
		.maskable_irq2_in_n(irq_n[2]), .bus_hold_grant_n, .bus_oe, .bus_park_high);
	swc_far_side swc_far_side_inst (.clk, .sys_rst, .bus_want, .hold, .nmi_fire, .irq_lvl,
		.bus_hold_grant_n, .bus_hold_request_n, .nmi_n, .irq_n);

	assign ev = {~bus_oe, sleep_resume, irq_ack_start, nmi_ack_start};
	always @(posedge clk) if (bus_park_high === 1'b1) parks++;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// a wake decision lands one cycle after the counter, plus the pin synchronizer
	function automatic logic [7:0] in_win(input int c);
		return {7'h00, c >= STAB && c <= STAB + 8};
	endfunction : in_win
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1;
		rv = io_rdata;
	endtask : rd
	task automatic watch(input logic [3:0] m, output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while ((ev & m) == 4'h0 && c < 60);
	endtask : watch
	task automatic sleep;
		@(posedge clk);
		sleep_exec <= 1'b1;
		@(posedge clk);
		sleep_exec <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({7'h00, osc_enable}, 8'h00);
	endtask : sleep
	task automatic bus_round;
		int p;
		watch(4'h8, n);
		chk({4'h0, ev}, 8'h08);
		@(posedge clk);
		#1;
		chk({7'h00, bus_hold_grant_n}, 8'h00);
		p = parks;
		watch(4'h4, n);
		chk({4'h0, ev}, 8'h04);
		// exactly one cycle of driving high while the bus is taken back
		chk({7'h00, parks == p + 1}, 8'h01);
		@(posedge clk);
		bus_want <= 1'b0;
	endtask : bus_round
	task automatic close_out;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		fails++;
		close_out();
	end
	initial begin
		{io_wr, io_rd, sleep_exec, bus_want, nmi_fire, global_irq_enable_flag} = '0;
		{io_addr, io_wdata, irq_lvl} = '0;
		hold = 8'h01;
		sys_rst = 1'b1;
		seed = 32'he08a_4604;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(SWC_IRQCTL_OFF);
		chk(rv, SWC_IRQCTL_RST);
		rd(SWC_IOC_OFF);
		chk(rv, SWC_IOC_RST);
		rd(SWC_CPUCTL_OFF);
		chk(rv, SWC_CPUCTL_RST);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			wr(SWC_IOC_OFF, seed[7:0]);
			rd(SWC_IOC_OFF);
			chk(rv, seed[7:0]);
		end
		wr(8'h35, 8'hff);
		rd(8'h35);
		chk(rv, 8'h00);
		wr(SWC_CPUCTL_OFF, 8'h08);
		wr(SWC_IOC_OFF, 8'h20);
		chk({7'h00, idle_select}, 8'h01);
		wr(SWC_IOC_OFF, 8'h00);
		wr(SWC_CPUCTL_OFF, 8'h48);
		sleep();
		@(posedge clk);
		bus_want <= 1'b1;
		irq_lvl <= 3'h2;
		watch(4'hf, n);
		chk({4'h0, ev}, 8'h00);
		chk({7'h00, osc_enable}, 8'h00);
		@(posedge clk);
		{bus_want, irq_lvl} <= 4'h1;
		repeat (4) @(posedge clk);
		irq_lvl <= 3'h0;
		watch(4'hf, n);
		chk({4'h0, ev}, 8'h00);
		chk({7'h00, osc_enable}, 8'h00);
		@(posedge clk);
		nmi_fire <= 1'b1;
		@(posedge clk);
		nmi_fire <= 1'b0;
		watch(4'hf, n);
		chk({4'h0, ev}, 8'h01);
		chk(in_win(n), 8'h01);
		wr(SWC_IRQCTL_OFF, 8'h07);
		for (int i = 0; i < 6; i++) begin
			sleep();
			@(posedge clk);
			global_irq_enable_flag <= (i < 3);
			irq_lvl <= 3'h1 << (i % 3);
			watch(4'hf, n);
			chk({4'h0, ev}, (i < 3) ? 8'h02 : 8'h04);
			chk(in_win(n), 8'h01);
			if (i < 3)
				chk({6'h00, irq_ack_id}, 8'(i));
			@(posedge clk);
			irq_lvl <= 3'h0;
		end
		wr(SWC_CPUCTL_OFF, 8'h68);
		sleep();
		@(posedge clk);
		seed = xs(seed);
		hold <= {4'h0, seed[3:0]} + 8'h01;
		bus_want <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk({6'h00, osc_enable, clk_run}, 8'h02);
		bus_round();
		@(posedge clk);
		bus_want <= 1'b1;
		bus_round();
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule : swc_standby_wake_tb_top
